//--- ncc_pkg.sv
package ncc_pkg;
   // escape pattern in the five high bits of the first opcode byte
   localparam logic [4:0] ESC_PAT = 5'h1b;
   // host queue status codes
   localparam logic [1:0] QS_NONE = 2'h0;
   localparam logic [1:0] QS_FIRST = 2'h1;
   localparam logic [1:0] QS_FLUSH = 2'h2;
   localparam logic [1:0] QS_NEXT = 2'h3;
   // status word field positions
   localparam int SW_BUSY = 15;
   localparam int SW_C3 = 14;
   localparam int SW_TOP = 11;
   localparam int SW_C2 = 10;
   localparam int SW_IRQ = 7;
   // control word: low six bits mask exceptions, bit 7 masks the request
   localparam int CW_IEM = 7;
   localparam logic [15:0] CW_RST = 16'h00bf;
   localparam logic [2:0] TOP_RST = 3'h0;
   // opcode decode
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] OP_CW = 3'h1;
   localparam logic [2:0] OP_SW = 3'h5;
   localparam logic [2:0] OP_MISC = 3'h3;
   localparam logic [2:0] RF_LDCW = 3'h5;
   localparam logic [2:0] RF_STCW = 3'h7;
   localparam logic [2:0] RF_STSW = 3'h7;
   localparam logic [2:0] RF_CMP = 3'h2;
   localparam logic [7:0] MRM_CLEX = 8'he2;
   localparam logic [7:0] MRM_INIT = 8'he3;
   // widths
   localparam int REG_W = 80;
   localparam int DP_W = 68;
   localparam int NREG = 8;
   // numeric execution time, a least time
   localparam int EXEC_NS = 300;
   localparam int CLK_NS = 100;
   localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
   // host bus as seen by the snooper
   typedef struct packed {
      logic fetch;        // code byte on data[7:0]
      logic addr_stb;     // address phase of a host read
      logic data_stb;     // data phase of a host read
      logic [19:0] addr;
      logic [15:0] data;
   } ncc_hbus_t;
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0] b;
   } ncc_qent_t;
   typedef struct packed {
      logic [19:0] ins_addr;
      logic [10:0] opcode;
      logic [19:0] opnd_addr;
   } ncc_expt_t;
   typedef enum {CU_IDLE, CU_MODRM, CU_ADDR, CU_DATA, CU_LOAD, CU_ISSUE, CU_CWAIT} ncc_cu_t;
   typedef enum {BE_IDLE, BE_REQ, BE_WAITG, BE_XFER, BE_REL} ncc_be_t;
   typedef enum {NE_IDLE, NE_EXEC, NE_STORE, NE_SWAIT} ncc_ne_t;
endpackage

//--- ncc_ctrl.sv
`timescale 1ns/1ps
// How it works
// RULE_01: control and execution units run side by side
// RULE_02: shadow host queue from fetches and queue status
// RULE_03: ignore opcodes lacking the escape pattern
// RULE_04: control class runs here, others go to execution
// RULE_05: host does one discarded read for memory escapes
// RULE_06: host runs no cycle for register escapes
// RULE_07: latch operand address from the discarded read
// RULE_08: load takes first word, bus fetches the rest
// RULE_09: store ignores read data, writes later over bus
// RULE_10: eight stack registers of 80 bits
// RULE_11: execution data path is 68 bits wide
// RULE_12: push decrements then writes; pop reads then increments
// RULE_13: top pointer wraps modulo eight
// RULE_14: operand i selects register top plus i
// RULE_15: status bit 15 shows busy
// RULE_16: compares set bits 14 and 10 to 8
// RULE_17: status bits 13 to 11 hold the top pointer
// RULE_18: status bit 7 marks pending host request
// RULE_19: status bits 5 to 0 record exceptions
// RULE_20: status seen only by store, control set by load
// RULE_21: every instruction records its pointers
// RULE_22: escape pattern 11011, pointer keeps eleven opcode bits
// RULE_23: busy output high while executing
// RULE_24: bus taken over request/grant handshake
// RULE_25: interrupt output follows pending bit
module ncc_ctrl #(
   parameter int QDEPTH = 6,
   parameter int EXEC_CYC = ncc_pkg::EXEC_CYC
) (
   input wire logic i_ref_clk,                 // 10 MHz host clock
   input wire logic i_sys_rst,                 // synchronous reset, high
   input wire ncc_pkg::ncc_hbus_t i_hbus,      // snooped host bus
   input wire logic [1:0] i_qs,                // host queue status
   input wire logic i_rqgt_i,                  // request/grant line in
   output logic o_rqgt_o,                      // request/grant line out
   output logic o_rqgt_oe,                     // request/grant drive enable
   output logic [19:0] o_mem_addr,             // own bus cycle address
   output logic [15:0] o_mem_wdata,            // own bus write data
   output logic o_mem_rd,                      // own read cycle
   output logic o_mem_wr,                      // own write cycle
   input wire logic i_mem_ready,               // own cycle completes
   input wire logic [15:0] i_mem_rdata,        // own read data
   input wire logic [5:0] i_neu_exc,           // exceptions from arithmetic
   output logic o_busy,                        // executing
   output logic o_int_req,                     // interrupt request to host
   output ncc_pkg::ncc_expt_t o_expt           // exception pointers
);
   localparam int QW = $clog2(QDEPTH);

   if (QDEPTH < 2 || EXEC_CYC < 1)
   begin : g_chk
      $error("ncc_ctrl: QDEPTH must be >= 2 and EXEC_CYC >= 1");
   end

   ncc_pkg::ncc_qent_t q_r [QDEPTH];
   logic [QW-1:0] q_rd_r, q_wr_r;
   logic [QW:0] q_cnt_r;
   ncc_pkg::ncc_qent_t head;
   logic q_pop, q_push, q_flush;

   // queue shadow; host and device consume the same bytes in the same order
   assign head = q_r[q_rd_r];
   assign q_flush = (i_qs == ncc_pkg::QS_FLUSH);
   assign q_pop = (i_qs == ncc_pkg::QS_FIRST || i_qs == ncc_pkg::QS_NEXT) && q_cnt_r != '0; // see RULE_02
   assign q_push = i_hbus.fetch && (q_cnt_r != (QW+1)'(QDEPTH) || q_pop);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || q_flush)
      begin
         q_rd_r <= '0;
         q_wr_r <= '0;
         q_cnt_r <= '0;
      end
      else
      begin
         if (q_push)
            q_wr_r <= (q_wr_r == QW'(QDEPTH - 1)) ? '0 : q_wr_r + 1'b1; // see RULE_02
         if (q_pop)
            q_rd_r <= (q_rd_r == QW'(QDEPTH - 1)) ? '0 : q_rd_r + 1'b1;
         q_cnt_r <= q_cnt_r + (QW+1)'(q_push) - (QW+1)'(q_pop);
      end
   end

   // queue storage needs no reset; entries are only read behind the count
   always_ff @(posedge i_ref_clk)
   begin
      if (q_push)
         q_r[q_wr_r] <= '{addr: i_hbus.addr, b: i_hbus.data[7:0]};
   end

   // instruction control unit state
   ncc_pkg::ncc_cu_t cu_r;
   ncc_pkg::ncc_be_t be_r;
   ncc_pkg::ncc_ne_t ne_r;
   logic [19:0] ins_addr_r, opnd_r;
   logic [2:0] ophi_r, top_r, nwords, be_first, be_last, be_idx_r, be_end_r;
   logic [7:0] mrm_r;
   logic [15:0] cw_r, sw;
   logic [79:0] obuf_r, wbuf_r;
   logic [5:0] exc_r;
   logic [3:0] cc_r;
   logic is_mem, is_load, is_ctl, issue_go, neu_go, ctl_clex, ctl_init, be_start, be_wr, be_done, irq;

   assign is_mem = (mrm_r[7:6] != ncc_pkg::MOD_REG);
   assign is_load = ~mrm_r[4];
   assign nwords = {1'b0, ophi_r[2:1]} + 3'h1;
   // control class is handled here and never reaches execution
   assign is_ctl = is_mem ? ((ophi_r == ncc_pkg::OP_CW && (mrm_r[5:3] == ncc_pkg::RF_LDCW
      || mrm_r[5:3] == ncc_pkg::RF_STCW)) || (ophi_r == ncc_pkg::OP_SW && mrm_r[5:3] == ncc_pkg::RF_STSW))
      : (ophi_r == ncc_pkg::OP_MISC && (mrm_r == ncc_pkg::MRM_CLEX || mrm_r == ncc_pkg::MRM_INIT)); // see RULE_04
   assign issue_go = (cu_r == ncc_pkg::CU_ISSUE) && ne_r == ncc_pkg::NE_IDLE;
   assign neu_go = issue_go && !is_ctl; // see RULE_04
   assign ctl_clex = issue_go && is_ctl && !is_mem && mrm_r == ncc_pkg::MRM_CLEX;
   assign ctl_init = issue_go && is_ctl && !is_mem && mrm_r == ncc_pkg::MRM_INIT;

   // decode sequence; runs while the execution unit is still busy
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         cu_r <= ncc_pkg::CU_IDLE;
         ins_addr_r <= '0;
         ophi_r <= '0;
         mrm_r <= '0;
         opnd_r <= '0;
      end
      else if (q_flush)
         cu_r <= ncc_pkg::CU_IDLE;
      else
      begin
         case (cu_r) // see RULE_01
            ncc_pkg::CU_IDLE:
               if (q_pop && i_qs == ncc_pkg::QS_FIRST && head.b[7:3] == ncc_pkg::ESC_PAT) // see RULE_03
               begin
                  ins_addr_r <= head.addr;
                  ophi_r <= head.b[2:0]; // see RULE_22
                  cu_r <= ncc_pkg::CU_MODRM;
               end
            ncc_pkg::CU_MODRM:
               if (q_pop && i_qs == ncc_pkg::QS_NEXT)
               begin
                  mrm_r <= head.b;
                  // the host reads only for a memory operand
                  cu_r <= (head.b[7:6] != ncc_pkg::MOD_REG) ? ncc_pkg::CU_ADDR : ncc_pkg::CU_ISSUE; // see RULE_06
               end
               else if (q_pop)
                  cu_r <= ncc_pkg::CU_IDLE;
            ncc_pkg::CU_ADDR:
               if (i_hbus.addr_stb)
               begin
                  opnd_r <= i_hbus.addr; // see RULE_07
                  cu_r <= ncc_pkg::CU_DATA; // see RULE_05
               end
            ncc_pkg::CU_DATA:
               if (i_hbus.data_stb)
                  cu_r <= (is_load && !is_ctl && nwords != 3'h1) ? ncc_pkg::CU_LOAD : ncc_pkg::CU_ISSUE;
            ncc_pkg::CU_LOAD:
               if (be_done)
                  cu_r <= ncc_pkg::CU_ISSUE;
            ncc_pkg::CU_ISSUE:
               if (ne_r == ncc_pkg::NE_IDLE)
                  cu_r <= (is_ctl && is_mem && !is_load) ? ncc_pkg::CU_CWAIT : ncc_pkg::CU_IDLE;
            ncc_pkg::CU_CWAIT:
               if (be_done)
                  cu_r <= ncc_pkg::CU_IDLE;
            default:
               cu_r <= ncc_pkg::CU_IDLE;
         endcase
      end
   end

   // control word is written by its load instruction and set back to CW_RST by init
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || ctl_init)
         cw_r <= ncc_pkg::CW_RST;
      else if (cu_r == ncc_pkg::CU_DATA && i_hbus.data_stb && is_ctl && is_load)
         cw_r <= i_hbus.data; // see RULE_20
   end

   // pointers taken at issue of every instruction
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_expt <= '0;
      else if (issue_go)
      begin
         o_expt.ins_addr <= ins_addr_r; // see RULE_21
         o_expt.opcode <= {ophi_r, mrm_r}; // see RULE_22
         if (is_mem)
            o_expt.opnd_addr <= opnd_r;
      end
   end

   // operand buffer: first word from the host read, rest from own cycles
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         obuf_r <= '0;
      else if (cu_r == ncc_pkg::CU_DATA && i_hbus.data_stb && is_load)
         obuf_r <= {64'h0, i_hbus.data}; // see RULE_08
      else if (be_r == ncc_pkg::BE_XFER && !be_wr && i_mem_ready)
         obuf_r[{be_idx_r, 4'h0} +: 16] <= i_mem_rdata;
   end

   // bus engine: load rest, control store, or numeric store
   assign be_start = (be_r == ncc_pkg::BE_IDLE) && ((cu_r == ncc_pkg::CU_DATA && i_hbus.data_stb && is_load
      && !is_ctl && nwords != 3'h1) || (issue_go && is_ctl && is_mem && !is_load)
      || ne_r == ncc_pkg::NE_STORE); // see RULE_08
   assign be_first = (ne_r == ncc_pkg::NE_STORE || cu_r == ncc_pkg::CU_ISSUE) ? 3'h0 : 3'h1;
   assign be_last = (cu_r == ncc_pkg::CU_ISSUE) ? 3'h0 : nwords - 3'h1;
   assign be_done = (be_r == ncc_pkg::BE_REL);
   // request and release are one-cycle pulses on the shared line
   assign o_rqgt_oe = (be_r == ncc_pkg::BE_REQ) || (be_r == ncc_pkg::BE_REL); // see RULE_24
   assign o_rqgt_o = o_rqgt_oe;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         be_r <= ncc_pkg::BE_IDLE;
         be_wr <= 1'b0;
         be_idx_r <= '0;
         be_end_r <= '0;
         o_mem_addr <= '0;
         o_mem_wdata <= '0;
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
      end
      else
      begin
         case (be_r)
            ncc_pkg::BE_IDLE:
               if (be_start)
               begin
                  be_wr <= (cu_r != ncc_pkg::CU_DATA);
                  be_idx_r <= be_first;
                  be_end_r <= be_last;
                  be_r <= ncc_pkg::BE_REQ;
               end
            ncc_pkg::BE_REQ:
               be_r <= ncc_pkg::BE_WAITG;
            ncc_pkg::BE_WAITG:
               if (i_rqgt_i)
               begin
                  o_mem_addr <= opnd_r + {16'h0, be_idx_r, 1'b0};
                  o_mem_wdata <= wbuf_r[{be_idx_r, 4'h0} +: 16]; // see RULE_09
                  o_mem_rd <= !be_wr;
                  o_mem_wr <= be_wr;
                  be_r <= ncc_pkg::BE_XFER;
               end
            ncc_pkg::BE_XFER:
               if (i_mem_ready)
               begin
                  // words follow back to back without releasing the bus
                  if (be_idx_r == be_end_r)
                  begin
                     o_mem_rd <= 1'b0;
                     o_mem_wr <= 1'b0;
                     be_r <= ncc_pkg::BE_REL;
                  end
                  else
                  begin
                     o_mem_addr <= opnd_r + {16'h0, be_idx_r + 3'h1, 1'b0};
                     o_mem_wdata <= wbuf_r[{be_idx_r + 3'h1, 4'h0} +: 16];
                  end
                  be_idx_r <= be_idx_r + 3'h1;
               end
            ncc_pkg::BE_REL:
               be_r <= ncc_pkg::BE_IDLE;
            default:
               be_r <= ncc_pkg::BE_IDLE;
         endcase
      end
   end

   // numeric execution unit
   logic [79:0] st_r [ncc_pkg::NREG];
   logic [2:0] phys, top_dn;
   logic [7:0] x_mrm_r;
   logic [79:0] x_op_r;
   logic [15:0] ecnt_r;
   logic [ncc_pkg::DP_W-1:0] dp_a, dp_b;
   logic x_mem, x_done;

   assign x_mem = (x_mrm_r[7:6] != ncc_pkg::MOD_REG);
   assign phys = top_r + x_mrm_r[2:0]; // see RULE_14
   assign top_dn = top_r - 3'h1; // see RULE_13
   assign dp_a = st_r[top_r][ncc_pkg::DP_W-1:0]; // see RULE_11
   assign dp_b = st_r[phys][ncc_pkg::DP_W-1:0];
   assign x_done = (ne_r == ncc_pkg::NE_EXEC) && ecnt_r == 16'(EXEC_CYC - 1);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || ctl_init)
      begin
         ne_r <= ncc_pkg::NE_IDLE;
         top_r <= ncc_pkg::TOP_RST;
         cc_r <= '0;
         ecnt_r <= '0;
         x_mrm_r <= '0;
         x_op_r <= '0;
         wbuf_r <= '0;
      end
      else
      begin
         case (ne_r)
            ncc_pkg::NE_IDLE:
               if (neu_go)
               begin
                  x_mrm_r <= mrm_r;
                  x_op_r <= obuf_r;
                  ecnt_r <= '0;
                  ne_r <= ncc_pkg::NE_EXEC;
               end
               else if (cu_r == ncc_pkg::CU_ISSUE && is_ctl && is_mem && !is_load)
                  wbuf_r <= {64'h0, (mrm_r[5:3] == ncc_pkg::RF_STSW && ophi_r == ncc_pkg::OP_SW) ? sw : cw_r};
            ncc_pkg::NE_EXEC:
               if (x_done)
               begin
                  ne_r <= ncc_pkg::NE_IDLE;
                  if (x_mem && !x_mrm_r[4])
                     top_r <= top_dn; // see RULE_12
                  else if (x_mem)
                  begin
                     wbuf_r <= st_r[top_r]; // see RULE_12
                     ne_r <= ncc_pkg::NE_STORE;
                  end
                  else if (x_mrm_r[5:3] == ncc_pkg::RF_CMP)
                     cc_r <= {dp_a == dp_b, 2'b00, dp_a < dp_b}; // see RULE_16
               end
               else
                  ecnt_r <= ecnt_r + 16'h1;
            ncc_pkg::NE_STORE:
               if (be_r == ncc_pkg::BE_IDLE)
                  ne_r <= ncc_pkg::NE_SWAIT;
            ncc_pkg::NE_SWAIT:
               if (be_done)
               begin
                  if (x_mrm_r[3])
                     top_r <= top_r + 3'h1; // see RULE_13
                  ne_r <= ncc_pkg::NE_IDLE;
               end
            default:
               ne_r <= ncc_pkg::NE_IDLE;
         endcase
      end
   end

   // stack file, one generate entry per register
   for (genvar gi = 0; gi < ncc_pkg::NREG; gi++)
   begin : g_st
      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
            st_r[gi] <= '0; // see RULE_10
         else if (x_done && x_mem && !x_mrm_r[4] && top_dn == 3'(gi))
            st_r[gi] <= x_op_r; // see RULE_12
         else if (x_done && !x_mem && x_mrm_r[5:3] != ncc_pkg::RF_CMP && top_r == 3'(gi))
            st_r[gi] <= st_r[phys];
      end
   end

   // exceptions are sticky; a same-cycle report beats a clear
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         exc_r <= '0;
      else
         exc_r <= ((ctl_clex || ctl_init) ? 6'h00 : exc_r)
                  | ((ne_r == ncc_pkg::NE_EXEC) ? i_neu_exc : 6'h00); // see RULE_19
   end

   // status word exists only as the source of its store instruction
   assign irq = |(exc_r & ~cw_r[5:0]) && !cw_r[ncc_pkg::CW_IEM]; // see RULE_18
   assign sw = {o_busy, cc_r[3], top_r, cc_r[2:0], irq, 1'b0, exc_r}; // see RULE_17
   assign o_busy = (ne_r != ncc_pkg::NE_IDLE); // see RULE_15, RULE_23
   assign o_int_req = irq; // see RULE_25
endmodule

//--- ncc_ctrl_sva.sv
`timescale 1ns/1ps
module ncc_ctrl_sva #(
   parameter int QDEPTH = 6,
   parameter int EXEC_CYC = 3
) (
   input wire logic i_ref_clk, // clock
   input wire logic i_sys_rst, // sync reset
   input wire ncc_pkg::ncc_hbus_t i_hbus, // snooped host bus
   input wire logic i_rqgt_i, // grant pulse
   input wire logic o_rqgt_o, // request value
   input wire logic o_rqgt_oe, // request strobe
   input wire logic [19:0] o_mem_addr, // own address
   input wire logic [15:0] o_mem_wdata, // own write data
   input wire logic o_mem_rd, // own read
   input wire logic o_mem_wr, // own write
   input wire logic i_mem_ready, // cycle done
   input wire logic o_busy, // executing
   input wire logic o_int_req // request to host
);
   logic owned_r;
   logic [19:0] opnd_r;
   default clocking dcb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   // ownership: grant takes it, next strobe returns it
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         owned_r <= 1'b0;
      else if (i_rqgt_i)
         owned_r <= 1'b1;
      else if (o_rqgt_oe && owned_r)
         owned_r <= 1'b0;
   end
   // last host read address
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         opnd_r <= '0;
      else if (i_hbus.addr_stb)
         opnd_r <= i_hbus.addr;
   end
   sequence s_release;
      !o_mem_rd && !o_mem_wr && o_rqgt_oe;
   endsequence
   sequence s_next(logic s);
      s && (o_mem_addr == $past(o_mem_addr) + 20'h2);
   endsequence
   reset_quiet_a: assert property (disable iff (1'b0)
      $fell(i_sys_rst) |-> !o_busy && !o_int_req && !o_mem_rd && !o_mem_wr && !o_rqgt_oe)
      else $error("outputs active right after reset");
   rq_pulse_a: assert property (o_rqgt_oe |-> o_rqgt_o ##1 !o_rqgt_oe)
      else $error("request strobe not a single pulse");
   bus_owned_a: assert property ((o_mem_rd || o_mem_wr) |-> owned_r)
      else $error("own cycle without grant");
   grant_go_a: assert property (i_rqgt_i |=> (o_mem_rd || o_mem_wr))
      else $error("no cycle right after grant");
   cyc_hold_a: assert property ((o_mem_rd || o_mem_wr) && !i_mem_ready |=>
      $stable({o_mem_rd, o_mem_wr, o_mem_addr}) && (!o_mem_wr || $stable(o_mem_wdata)))
      else $error("own cycle changed before ready");
   rd_next_a: assert property (o_mem_rd && i_mem_ready |=> s_next(o_mem_rd) or s_release)
      else $error("read words not back to back");
   wr_next_a: assert property (o_mem_wr && i_mem_ready |=> s_next(o_mem_wr) or s_release)
      else $error("write words not back to back");
   rd_start_a: assert property ($rose(o_mem_rd) |-> o_mem_addr == opnd_r + 20'h2)
      else $error("load rest not after first word");
   wr_start_a: assert property ($rose(o_mem_wr) |-> o_mem_addr == opnd_r)
      else $error("store not at latched address");
endmodule
bind ncc_ctrl ncc_ctrl_sva #(.QDEPTH(QDEPTH), .EXEC_CYC(EXEC_CYC)) i_ncc_ctrl_sva (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hbus(i_hbus), .i_rqgt_i(i_rqgt_i),
   .o_rqgt_o(o_rqgt_o), .o_rqgt_oe(o_rqgt_oe), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
   .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .i_mem_ready(i_mem_ready), .o_busy(o_busy),
   .o_int_req(o_int_req));

//--- ncc_host.sv
`timescale 1ns/1ps
module ncc_host (
   input wire logic i_ref_clk, // clock
   input wire logic i_sys_rst, // sync reset
   input wire logic i_rqgt_o, // request value
   input wire logic i_rqgt_oe, // request strobe
   output logic o_grant, // grant pulse
   input wire logic i_mem_rd, // read cycle
   input wire logic i_mem_wr, // write cycle
   input wire logic [19:0] i_mem_addr, // cycle address
   input wire logic [15:0] i_mem_wdata, // write data
   output logic o_mem_ready, // cycle done
   output logic [15:0] o_mem_rdata, // read data
   input wire logic [3:0] i_gdly, // grant wait
   input wire logic [3:0] i_wdly // ready wait
);
   logic [15:0] mem [0:1023];
   logic owned_r, pend_r;
   logic [3:0] gcnt_r, wcnt_r;
   // grant after a set wait; a strobe while owned releases
   always @(posedge i_ref_clk)
   begin
      o_grant <= 1'b0;
      if (i_sys_rst)
      begin
         owned_r <= 1'b0;
         pend_r <= 1'b0;
      end
      else if (i_rqgt_oe && i_rqgt_o && owned_r)
         owned_r <= 1'b0;
      else if (i_rqgt_oe && i_rqgt_o)
      begin
         pend_r <= 1'b1;
         gcnt_r <= 4'h0;
      end
      else if (pend_r && gcnt_r >= i_gdly)
      begin
         o_grant <= 1'b1;
         pend_r <= 1'b0;
         owned_r <= 1'b1;
      end
      else if (pend_r)
         gcnt_r <= gcnt_r + 4'h1;
   end
   // memory; idle read data toggles so stale data never passes
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_mem_ready <= 1'b0;
         wcnt_r <= 4'h0;
         o_mem_rdata <= 16'h5a5a;
      end
      else if (o_mem_ready || !(i_mem_rd || i_mem_wr) || wcnt_r < i_wdly)
      begin
         o_mem_ready <= 1'b0;
         wcnt_r <= (i_mem_rd || i_mem_wr) && !o_mem_ready ? wcnt_r + 4'h1 : 4'h0;
         o_mem_rdata <= ~o_mem_rdata;
      end
      else
      begin
         o_mem_ready <= 1'b1;
         wcnt_r <= 4'h0;
         o_mem_rdata <= i_mem_rd ? mem[i_mem_addr[10:1]] : ~o_mem_rdata;
         if (i_mem_wr)
            mem[i_mem_addr[10:1]] <= i_mem_wdata;
      end
   end
endmodule

//--- ncc_ctrl_bench.sv
`timescale 1ns/1ps
module ncc_ctrl_bench;
   logic i_ref_clk, i_sys_rst, grant, rq_o, rq_oe, mem_rd, mem_wr, mem_ready, busy, int_req, busy_seen;
   ncc_pkg::ncc_hbus_t hb;
   ncc_pkg::ncc_expt_t expt;
   logic [1:0] qs;
   logic [19:0] mem_addr, ip;
   logic [15:0] mem_wdata, mem_rdata;
   logic [15:0] w [0:3];
   logic [5:0] neu_exc, exc_val;
   logic [3:0] gdly, wdly;
   int fails, tests_run;
   ncc_ctrl #(.QDEPTH(6), .EXEC_CYC(3)) i_ncc_ctrl (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
      .i_hbus(hb), .i_qs(qs), .i_rqgt_i(grant), .o_rqgt_o(rq_o), .o_rqgt_oe(rq_oe),
      .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr),
      .i_mem_ready(mem_ready), .i_mem_rdata(mem_rdata), .i_neu_exc(neu_exc), .o_busy(busy),
      .o_int_req(int_req), .o_expt(expt));
   ncc_host i_ncc_host (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_rqgt_o(rq_o),
      .i_rqgt_oe(rq_oe), .o_grant(grant), .i_mem_rd(mem_rd), .i_mem_wr(mem_wr),
      .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .o_mem_ready(mem_ready),
      .o_mem_rdata(mem_rdata), .i_gdly(gdly), .i_wdly(wdly));
   initial
   begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   // exceptions count only while busy
   always @(posedge i_ref_clk)
      neu_exc <= (busy === 1'b1) ? exc_val : 6'h00;
   task automatic results;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one host bus cycle
   task automatic drv(input logic [2:0] f, input logic [19:0] a, input logic [15:0] d, input logic [1:0] q);
      @(posedge i_ref_clk);
      hb <= '{f[2], f[1], f[0], a, d};
      qs <= q;
   endtask
   // bounded wait for ten quiet cycles
   task automatic settle;
      int q, n;
      q = 0;
      n = 0;
      busy_seen = 1'b0;
      while (q < 10 && n < 400)
      begin
         @(posedge i_ref_clk);
         n++;
         if (busy === 1'b1)
            busy_seen = 1'b1;
         q = ({busy, mem_rd, mem_wr, rq_oe} === 4'h0) ? q + 1 : 0;
      end
      if (n >= 400)
      begin
         fails++;
         $display("wrong value at %0t: operation never settled", $time);
      end
   endtask
   // host side of one escape
   task automatic issue(input logic [7:0] b1, input logic [7:0] b2, input logic [19:0] a, input logic [15:0] d);
      drv(3'h4, ip, {8'h00, b1}, ncc_pkg::QS_NONE);
      drv(3'h4, ip + 20'h1, {8'h00, b2}, ncc_pkg::QS_NONE);
      drv(3'h0, ~ip, 16'h5a5a, ncc_pkg::QS_FIRST);
      drv(3'h0, ip, 16'ha5a5, ncc_pkg::QS_NEXT);
      if (b2[7:6] != ncc_pkg::MOD_REG)
      begin
         drv(3'h2, a, ~d, ncc_pkg::QS_NONE);
         drv(3'h1, a, d, ncc_pkg::QS_NONE);
      end
      drv(3'h0, ~a, ~d, ncc_pkg::QS_NONE);
      settle();
      chk(32'(expt.ins_addr), 32'(ip), "instruction address");
      chk(32'(expt.opcode), 32'({b1[2:0], b2}), "opcode");
      if (b2[7:6] != ncc_pkg::MOD_REG)
         chk(32'(expt.opnd_addr), 32'(a), "operand address");
      ip = ip + 20'h2;
   endtask
   task automatic rdsw(input logic [15:0] mask, input logic [15:0] exp);
      i_ncc_host.mem[10'h180] = ~exp;
      issue(8'hdd, 8'h3e, 20'h00300, 16'hffff);
      chk(32'(i_ncc_host.mem[10'h180] & mask), 32'(exp), "status word");
   endtask
   task automatic stcw(input logic [15:0] exp);
      i_ncc_host.mem[10'h288] = ~exp;
      issue(8'hd9, 8'h3e, 20'h00510, 16'hffff);
      chk(32'(i_ncc_host.mem[10'h288]), 32'(exp), "control word");
   endtask
   // watchdog well past the expected run
   initial
   begin
      #3000000;
      fails++;
      results();
   end
   initial
   begin
      fails = 0;
      tests_run = 0;
      i_sys_rst = 1'b1;
      hb = '0;
      qs = ncc_pkg::QS_NONE;
      neu_exc = 6'h00;
      exc_val = 6'h00;
      gdly = 4'h5;
      wdly = 4'h2;
      ip = 20'h01000;
      w = '{16'h0001, 16'h2222, 16'h3333, 16'h4444};
      for (int k = 1; k < 4; k++)
         i_ncc_host.mem[10'h100 + k] = w[k];
      repeat (16) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_ref_clk);
      @(posedge i_ref_clk);
      chk(32'(busy), 32'h0, "busy after reset");
      chk(32'(int_req), 32'h0, "request after reset");
      rdsw(16'h7fff, 16'h0000);
      // host-only opcodes, then a flushed escape
      drv(3'h4, 20'h80, 16'h90, ncc_pkg::QS_NONE);
      drv(3'h4, 20'h81, 16'h6, ncc_pkg::QS_NONE);
      drv(3'h4, 20'h82, 16'hd8, ncc_pkg::QS_FIRST);
      drv(3'h4, 20'h83, 16'h6, ncc_pkg::QS_FIRST);
      drv(3'h0, 20'h84, 16'hffff, ncc_pkg::QS_FIRST);
      drv(3'h0, 20'h85, 16'h0, ncc_pkg::QS_FLUSH);
      drv(3'h0, 20'h86, 16'hffff, ncc_pkg::QS_NONE);
      settle();
      chk(32'(busy_seen), 32'h0, "ignored opcode ran");
      chk(32'(expt.ins_addr), 32'(ip - 20'h2), "pointers moved");
      issue(8'hde, 8'h06, 20'h00200, w[0]);
      wdly = 4'h0;
      issue(8'hd8, 8'h06, 20'h00100, 16'h1234);
      chk(32'(busy_seen), 32'h1, "busy during load");
      issue(8'hd8, 8'hd1, 20'h0, 16'h0);
      rdsw(16'h7fff, 16'h3100);
      issue(8'hd8, 8'hd0, 20'h0, 16'h0);
      rdsw(16'h7fff, 16'h7000);
      issue(8'hd8, 8'h1e, 20'h00400, 16'hffff);
      chk(32'(i_ncc_host.mem[10'h200]), 32'h1234, "popped word");
      gdly = 4'h0;
      issue(8'hde, 8'h1e, 20'h00410, 16'hffff);
      for (int k = 0; k < 4; k++)
         chk(32'(i_ncc_host.mem[10'h208 + k]), 32'(w[k]), "stored word");
      rdsw(16'h3800, 16'h0000);
      exc_val = 6'h05;
      issue(8'hd8, 8'hc1, 20'h0, 16'h0);
      exc_val = 6'h00;
      chk(32'(int_req), 32'h0, "masked request");
      rdsw(16'h00bf, 16'h0005);
      issue(8'hd9, 8'h2e, 20'h00500, 16'h0000);
      chk(32'(int_req), 32'h1, "unmasked request");
      rdsw(16'h0080, 16'h0080);
      stcw(16'h0000);
      issue(8'hdb, 8'he2, 20'h0, 16'h0);
      chk(32'(int_req), 32'h0, "request after clear");
      rdsw(16'h00bf, 16'h0000);
      issue(8'hdb, 8'he3, 20'h0, 16'h0);
      stcw(ncc_pkg::CW_RST);
      results();
   end
endmodule
